// File: verilog/frc_pkg.sv
// Constants and types for the disk controller rate, power and reset control
package frc_pkg;
	localparam int          ADDR_W      = 10;
	localparam logic [9:0]  OFF_DOR     = 10'h002;
	localparam logic [9:0]  OFF_MSR_DSR = 10'h004;
	localparam logic [9:0]  OFF_DATA    = 10'h005;
	localparam logic [9:0]  OFF_MODE    = 10'h010;
	localparam logic [9:0]  OFF_CONF    = 10'h011;
	localparam logic [9:0]  OFF_PRECOMP_START_TRACK  = 10'h012;
	localparam logic [9:0]  OFF_STAT    = 10'h013;
	localparam logic [9:0]  OFF_CCR     = 10'h3F7;
	// Rate select and output register fields
	localparam int          DSR_SWRST   = 7;
	localparam int          DSR_LP      = 6;
	localparam int          DSR_PRE_LSB = 2;
	localparam int          DOR_RST     = 2;
	// Mode register fields
	localparam int          MODE_MANLP  = 0;
	localparam int          MODE_AUTOLP = 1;
	localparam int          MODE_FWR    = 2;
	localparam int          MODE_FRD    = 3;
	localparam int          MODE_BST    = 4;
	localparam int          MODE_PERP   = 5;
	localparam int          MODE_LOCK   = 7;
	// Configure register fields
	localparam int          CONF_FIFO   = 0;
	localparam int          CONF_THR    = 1;
	localparam int          CONF_ISEEK  = 5;
	localparam int          CONF_NOPOLL = 6;
	// Values after reset
	localparam logic [7:0]  DOR_RST_VAL  = 8'h00;
	localparam logic [7:0]  DSR_RST_VAL  = 8'h00;
	localparam logic [7:0]  MODE_RST_VAL = 8'h00;
	localparam logic [7:0]  CONF_RST_VAL = 8'h00;
	localparam logic [7:0]  PRECOMP_START_TRACK_RST   = 8'h00;
	localparam logic [7:0]  MSR_BUSY     = 8'h00;
	localparam logic [7:0]  MSR_READY    = 8'h80;
	// Rate codes
	localparam logic [1:0]  RATE_500K = 2'h0;
	localparam logic [1:0]  RATE_300K = 2'h1;
	localparam logic [1:0]  RATE_250K = 2'h2;
	localparam logic [1:0]  RATE_1M   = 2'h3;
	// Relative speed, units of 50 Kbps
	localparam logic [4:0]  SPD_250K = 5'h05;
	localparam logic [4:0]  SPD_300K = 5'h06;
	localparam logic [4:0]  SPD_500K = 5'h0A;
	localparam logic [4:0]  SPD_1M   = 5'h14;
	// Gaps and pre-erase lead, in bytes
	localparam logic [5:0]  GAP_STD   = 6'h16;
	localparam logic [5:0]  GAP_PERP  = 6'h29;
	localparam logic [5:0]  LEAD_1M   = 6'h26;
	localparam logic [5:0]  LEAD_500K = 6'h13;
	localparam logic [5:0]  LEAD_300K = 6'h0C;
	localparam logic [5:0]  LEAD_250K = 6'h0A;
	// Timing
	localparam int          CLK_NS      = 50;
	localparam int          INIT_NS     = 1000;
	localparam int          INIT_CYC    = (INIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int          AUTO_LP_MS  = 500;
	localparam int          AUTO_LP_CYC = AUTO_LP_MS * 1000000 / CLK_NS;
	localparam int          OSC_WAKE_MS = 2;
	localparam int          OSC_CYC     = OSC_WAKE_MS * 1000000 / CLK_NS;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              wr;
		logic              rd;
	} frc_bus_req_t;

	typedef struct packed {
		logic [1:0] rate;
		logic [4:0] speed;
		logic [3:0] filter;
	} frc_clk_cfg_t;

	typedef struct packed {
		logic       fifo_en;
		logic [3:0] fifo_threshold_param;
		logic       implied_seek;
		logic       poll_en;
		logic       fifo_write_disable;
		logic       fifo_read_disable;
		logic       burst_disable;
		logic       perp_mode;
	} frc_params_t;

	typedef enum logic [1:0] {FRC_INIT, FRC_RUN, FRC_DOWN, FRC_WAKE} frc_state_t;
endpackage

// File: verilog/frc_ctrl.sv
// Rate select, power down and reset sequencing for the disk controller
`timescale 1ns/100ps

// Functional notes
// - Data rate comes from configuration control register bits 1:0; others zero.
// - Rate select register bits 1:0 also set rate, same decoding.
// - Last write to either rate register wins.
// - Engine and separator clock scaling follow the selected rate.
// - Rate indicator pin follows last written rate bit 0.
// - Precompensation defaults after reset, replaceable through rate select register.
// - Precompensation start track resets to zero, set through its own start track register.
// - Rate select bit 6 enters low power one cycle after the bit registers; cleared on exit.
// - Manual low power is OR of register bit and mode bit.
// - Auto low power after 500 ms idle at 500 Kbps, persistent.
// - Power down stops controller clock and clears request-for-master.
// - Software reset through either register leaves power down.
// - Main status or data access wakes; request-for-master zero until stable.
// - Rate, output and configuration registers unaffected by power down.
// - Master reset restores defaults: fifo off, threshold 0, polling on.
// - Rate select reset bit self-clears; output register reset bit holds.
// - Lock keeps fifo, threshold, start track, auto low power and mode fifo/burst settings.
// - Status reads 00h after reset, then 80h within 2.5 us.
// - Registers besides status and data reachable even during reset, except mode, configure and start track writes while a reset is asserted.
// - Perpendicular write gate leads preamble by 38, 19, 12 or 10 bytes, by rate.
// - Perpendicular mode uses 41-byte id-to-data gap instead of 22.
// - Idle reports request-for-master set, data direction clear.
// - Four rates supported, each switching its separator filter.
module frc_ctrl #(
	parameter int AUTO_LP_CYCLES = frc_pkg::AUTO_LP_CYC,
	parameter int OSC_CYCLES     = frc_pkg::OSC_CYC
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst_n,
	// Register port
	input  wire frc_pkg::frc_bus_req_t bus,
	output logic [7:0]                rdata,
	// Controller core
	input  wire logic                 core_idle,
	input  wire logic [7:0]           core_msr,
	input  wire logic [7:0]           data_rdata,
	output logic                      data_rd,
	output logic                      data_wr,
	output logic [7:0]                data_wdata,
	output logic                      core_clk_en,
	output logic                      core_rst,
	output logic                      low_power,
	output frc_pkg::frc_clk_cfg_t     clk_cfg,
	output frc_pkg::frc_params_t      params,
	output logic [2:0]                precomp_sel,
	output logic [7:0]                precomp_start_track,
	output logic [5:0]                id_to_data_gap,
	// Disk side
	input  wire logic                 write_req,
	input  wire logic [7:0]           bytes_to_preamble,
	output logic                      write_gate_output,
	output logic                      rate_indicator_pin,
	output logic [7:0]                drive_ctrl
);
	localparam logic [31:0] AUTO_LIM = 32'(AUTO_LP_CYCLES) * 32'd10;

	frc_pkg::frc_state_t st_ff, nxt_st;
	logic [31:0]         cnt_ff, nxt_cnt;
	logic [31:0]         idle_cnt_ff, nxt_idle_cnt;
	logic                wg_ff, nxt_wg;
	logic [7:0]          dor_ff, nxt_dor;
	logic [1:0]          rate_ff, nxt_rate;
	logic [2:0]          pre_ff, nxt_pre;
	logic                dsr_lp_ff, nxt_dsr_lp;
	logic [7:0]          mode_ff, nxt_mode;
	logic [7:0]          conf_ff, nxt_conf;
	logic [7:0]          precomp_start_track_ff, nxt_precomp_start_track;
	logic [7:0]          rdata_ff, nxt_rdata;

	logic       dsr_wr, ccr_wr, dsr_rst, sw_rst, touch, man_req, auto_hit, lock;
	logic [4:0] speed;
	logic [3:0] filt;
	logic [5:0] lead;

	assign dsr_wr  = bus.wr && bus.addr == frc_pkg::OFF_MSR_DSR;
	assign ccr_wr  = bus.wr && bus.addr == frc_pkg::OFF_CCR;
	// rate select reset is a one-cycle pulse
	assign dsr_rst = dsr_wr && bus.wdata[frc_pkg::DSR_SWRST];
	// output register reset holds until cleared
	assign sw_rst  = dsr_rst || dor_ff[frc_pkg::DOR_RST];
	// status read or data access wakes the part
	assign touch   = (bus.rd && bus.addr == frc_pkg::OFF_MSR_DSR) ||
	                 ((bus.rd || bus.wr) && bus.addr == frc_pkg::OFF_DATA);
	// manual request is OR of both sources
	assign man_req = dsr_lp_ff || mode_ff[frc_pkg::MODE_MANLP];
	assign lock    = mode_ff[frc_pkg::MODE_LOCK];

	// fixed code table for both registers
	always_comb begin
		case (rate_ff)
			frc_pkg::RATE_500K: begin
				speed = frc_pkg::SPD_500K;
				lead  = frc_pkg::LEAD_500K;
				filt  = 4'h1;
			end
			frc_pkg::RATE_300K: begin
				speed = frc_pkg::SPD_300K;
				lead  = frc_pkg::LEAD_300K;
				filt  = 4'h2;
			end
			frc_pkg::RATE_250K: begin
				speed = frc_pkg::SPD_250K;
				lead  = frc_pkg::LEAD_250K;
				filt  = 4'h4;
			end
			default: begin
				speed = frc_pkg::SPD_1M;
				lead  = frc_pkg::LEAD_1M;
				filt  = 4'h8;
			end
		endcase
	end

	// fires once per idle entry; holds at limit until idle ends
	// counter steps by rate weight, so 500 Kbps gives nominal delay
	assign auto_hit = st_ff == frc_pkg::FRC_RUN && mode_ff[frc_pkg::MODE_AUTOLP] && core_idle &&
	                  idle_cnt_ff < AUTO_LIM && idle_cnt_ff + 32'(speed) >= AUTO_LIM;

	// Sequencer next state
	always_comb begin
		nxt_st       = st_ff;
		nxt_cnt      = cnt_ff;
		nxt_idle_cnt = idle_cnt_ff;
		if (!core_idle || !mode_ff[frc_pkg::MODE_AUTOLP]) begin
			nxt_idle_cnt = 32'h0;
		end else if (st_ff == frc_pkg::FRC_RUN && idle_cnt_ff < AUTO_LIM) begin
			nxt_idle_cnt = idle_cnt_ff + 32'(speed);
		end
		case (st_ff)
			frc_pkg::FRC_INIT: begin
				if (sw_rst) begin
					nxt_cnt = 32'h0;
				end else if (cnt_ff >= 32'(frc_pkg::INIT_CYC - 1)) begin
					nxt_st  = frc_pkg::FRC_RUN;
					nxt_cnt = 32'h0;
				end else begin
					nxt_cnt = cnt_ff + 32'h1;
				end
			end
			frc_pkg::FRC_RUN: begin
				if (sw_rst) begin
					nxt_st  = frc_pkg::FRC_INIT;
					nxt_cnt = 32'h0;
				end else if (man_req || auto_hit) begin
					nxt_st = frc_pkg::FRC_DOWN;
				end
			end
			frc_pkg::FRC_DOWN: begin
				if (sw_rst) begin
					nxt_st  = frc_pkg::FRC_INIT;
					nxt_cnt = 32'h0;
				end else if (touch) begin
					nxt_st  = frc_pkg::FRC_WAKE;
					nxt_cnt = 32'h0;
				end
			end
			frc_pkg::FRC_WAKE: begin
				if (sw_rst) begin
					nxt_st  = frc_pkg::FRC_INIT;
					nxt_cnt = 32'h0;
				end else if (cnt_ff >= 32'(OSC_CYCLES - 1)) begin
					nxt_st  = frc_pkg::FRC_RUN;
					nxt_cnt = 32'h0;
				end else begin
					nxt_cnt = cnt_ff + 32'h1;
				end
			end
			default: begin
				nxt_st  = frc_pkg::FRC_INIT;
				nxt_cnt = 32'h0;
			end
		endcase
		// gate opens early by pre-erase lead in perpendicular mode
		nxt_wg = write_req && core_clk_en && bytes_to_preamble <=
		         {2'h0, mode_ff[frc_pkg::MODE_PERP] ? lead : 6'h0};
	end

	// master reset returns sequencer to settle state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff       <= frc_pkg::FRC_INIT;
			cnt_ff      <= 32'h0;
			idle_cnt_ff <= 32'h0;
			wg_ff       <= 1'b0;
		end else begin
			st_ff       <= nxt_st;
			cnt_ff      <= nxt_cnt;
			idle_cnt_ff <= nxt_idle_cnt;
			wg_ff       <= nxt_wg;
		end
	end

	// Register file next state
	always_comb begin
		nxt_dor    = dor_ff;
		nxt_rate   = rate_ff;
		nxt_pre    = pre_ff;
		nxt_dsr_lp = dsr_lp_ff;
		nxt_mode   = mode_ff;
		nxt_conf   = conf_ff;
		nxt_precomp_start_track = precomp_start_track_ff;
		nxt_rdata  = 8'h00;
		// low power bits drop on exit; a new set wins
		if (st_ff == frc_pkg::FRC_DOWN && (touch || sw_rst)) begin
			nxt_dsr_lp                  = 1'b0;
			nxt_mode[frc_pkg::MODE_MANLP] = 1'b0;
		end
		// lock keeps listed parameters, others return to defaults
		if (sw_rst) begin
			nxt_mode = frc_pkg::MODE_RST_VAL;
			nxt_mode[frc_pkg::MODE_LOCK] = lock;
			nxt_conf = frc_pkg::CONF_RST_VAL;
			nxt_precomp_start_track = frc_pkg::PRECOMP_START_TRACK_RST;
			if (lock) begin
				nxt_mode[frc_pkg::MODE_BST:frc_pkg::MODE_FWR] =
					mode_ff[frc_pkg::MODE_BST:frc_pkg::MODE_FWR];
				nxt_mode[frc_pkg::MODE_AUTOLP] = mode_ff[frc_pkg::MODE_AUTOLP];
				nxt_conf[frc_pkg::CONF_THR+3:frc_pkg::CONF_FIFO] =
					conf_ff[frc_pkg::CONF_THR+3:frc_pkg::CONF_FIFO];
				nxt_precomp_start_track = precomp_start_track_ff;
			end
		end
		// these writes are taken in any state
		if (bus.wr) begin
			case (bus.addr)
				frc_pkg::OFF_DOR: nxt_dor = bus.wdata;
				frc_pkg::OFF_MSR_DSR: begin
					// rate select register carries rate too
					nxt_rate   = bus.wdata[1:0];
					nxt_pre    = bus.wdata[frc_pkg::DSR_PRE_LSB+2:frc_pkg::DSR_PRE_LSB];
					nxt_dsr_lp = bus.wdata[frc_pkg::DSR_LP];
				end
				// only bits 1:0 of configuration control used
				frc_pkg::OFF_CCR: nxt_rate = bus.wdata[1:0];
				frc_pkg::OFF_MODE: begin
					if (!sw_rst) begin
						nxt_mode = bus.wdata;
					end
				end
				frc_pkg::OFF_CONF: begin
					if (!sw_rst) begin
						nxt_conf = bus.wdata;
					end
				end
				frc_pkg::OFF_PRECOMP_START_TRACK: begin
					if (!sw_rst) begin
						nxt_precomp_start_track = bus.wdata;
					end
				end
				default: nxt_rdata = 8'h00;
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				frc_pkg::OFF_DOR: nxt_rdata = dor_ff;
				frc_pkg::OFF_MSR_DSR: begin
					// 00h during settle, 80h once ready
					// idle shows request set, direction clear
					if (st_ff != frc_pkg::FRC_RUN) begin
						nxt_rdata = frc_pkg::MSR_BUSY;
					end else if (core_idle) begin
						nxt_rdata = frc_pkg::MSR_READY;
					end else begin
						nxt_rdata = core_msr;
					end
				end
				frc_pkg::OFF_DATA: begin
					if (st_ff == frc_pkg::FRC_RUN) begin
						nxt_rdata = data_rdata;
					end
				end
				frc_pkg::OFF_MODE:   nxt_rdata = mode_ff;
				frc_pkg::OFF_CONF:   nxt_rdata = conf_ff;
				frc_pkg::OFF_PRECOMP_START_TRACK: nxt_rdata = precomp_start_track_ff;
				frc_pkg::OFF_STAT: begin
					nxt_rdata = {st_ff == frc_pkg::FRC_DOWN, st_ff == frc_pkg::FRC_WAKE,
					             st_ff == frc_pkg::FRC_INIT, pre_ff, rate_ff};
				end
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	// defaults: fifo off, threshold zero, polling on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dor_ff    <= frc_pkg::DOR_RST_VAL;
			rate_ff   <= frc_pkg::DSR_RST_VAL[1:0];
			pre_ff    <= frc_pkg::DSR_RST_VAL[frc_pkg::DSR_PRE_LSB+2:frc_pkg::DSR_PRE_LSB];
			dsr_lp_ff <= 1'b0;
			mode_ff   <= frc_pkg::MODE_RST_VAL;
			conf_ff   <= frc_pkg::CONF_RST_VAL;
			precomp_start_track_ff <= frc_pkg::PRECOMP_START_TRACK_RST;
			rdata_ff  <= 8'h00;
		end else begin
			dor_ff    <= nxt_dor;
			rate_ff   <= nxt_rate;
			pre_ff    <= nxt_pre;
			dsr_lp_ff <= nxt_dsr_lp;
			mode_ff   <= nxt_mode;
			conf_ff   <= nxt_conf;
			precomp_start_track_ff <= nxt_precomp_start_track;
			rdata_ff  <= nxt_rdata;
		end
	end

	// Data strobes pass only while running; reset blocks the fifo path
	assign data_rd     = bus.rd && bus.addr == frc_pkg::OFF_DATA && st_ff == frc_pkg::FRC_RUN;
	assign data_wr     = bus.wr && bus.addr == frc_pkg::OFF_DATA && st_ff == frc_pkg::FRC_RUN;
	assign data_wdata  = bus.wdata;
	assign rdata       = rdata_ff;
	// clock stopped in power down and during oscillator wait
	assign core_clk_en = st_ff == frc_pkg::FRC_RUN || st_ff == frc_pkg::FRC_INIT;
	assign core_rst    = st_ff == frc_pkg::FRC_INIT;
	assign low_power   = st_ff == frc_pkg::FRC_DOWN || st_ff == frc_pkg::FRC_WAKE;
	assign clk_cfg     = '{rate: rate_ff, speed: speed, filter: filt};
	assign params      = '{fifo_en: conf_ff[frc_pkg::CONF_FIFO],
	                       fifo_threshold_param: conf_ff[frc_pkg::CONF_THR+3:frc_pkg::CONF_THR],
	                       implied_seek: conf_ff[frc_pkg::CONF_ISEEK],
	                       poll_en: !conf_ff[frc_pkg::CONF_NOPOLL],
	                       fifo_write_disable: mode_ff[frc_pkg::MODE_FWR],
	                       fifo_read_disable: mode_ff[frc_pkg::MODE_FRD],
	                       burst_disable: mode_ff[frc_pkg::MODE_BST],
	                       perp_mode: mode_ff[frc_pkg::MODE_PERP]};
	assign precomp_sel         = pre_ff;
	assign precomp_start_track = precomp_start_track_ff;
	assign id_to_data_gap = mode_ff[frc_pkg::MODE_PERP] ? frc_pkg::GAP_PERP : frc_pkg::GAP_STD;
	assign write_gate_output = wg_ff;
	// pin follows last written rate bit 0
	assign rate_indicator_pin = rate_ff[0];
	// Motors and selects stay as software left them in power down
	assign drive_ctrl = dor_ff;
endmodule

// File: sim/frc_core_model.sv
// Behavioural controller core on the far side of the block
`timescale 1ns/100ps
module frc_core_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// From the block
	input  wire logic       core_clk_en,
	input  wire logic       data_wr,
	input  wire logic [7:0] data_wdata,
	// To the block
	output logic            core_idle,
	output logic [7:0]      core_msr,
	output logic [7:0]      data_rdata,
	output logic            write_req,
	output logic [7:0]      bytes_to_preamble
);
	logic [2:0] busy_ff;
	assign core_idle = busy_ff == 3'h0;
	assign core_msr  = core_idle ? 8'h80 : 8'h10;
	// Nothing moves while the block gates the core clock
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			busy_ff           <= 3'h0;
			data_rdata        <= 8'h00;
			write_req         <= 1'b0;
			bytes_to_preamble <= 8'h00;
		end else if (core_clk_en) begin
			write_req <= bytes_to_preamble != 8'h00;
			if (bytes_to_preamble != 8'h00)
				bytes_to_preamble <= bytes_to_preamble - 8'h01;
			if (busy_ff != 3'h0)
				busy_ff <= busy_ff - 3'h1;
			if (data_wr) begin
				busy_ff    <= 3'h4;
				data_rdata <= data_wdata;
				// Top bit starts a write 45 bytes before the preamble
				if (data_wdata[7]) begin
					write_req         <= 1'b1;
					bytes_to_preamble <= 8'h2D;
				end
			end
		end
	end
endmodule

// File: sim/frc_ctrl_properties.sv
// Concurrent checks on the rate, power and reset control ports
`timescale 1ns/100ps
module frc_ctrl_properties (
	// Clock and reset
	input wire logic                  mclk,
	input wire logic                  rst_n,
	// Register port
	input wire frc_pkg::frc_bus_req_t bus,
	input wire logic [7:0]            rdata,
	// Core side
	input wire logic                  data_rd,
	input wire logic                  data_wr,
	input wire logic                  core_clk_en,
	input wire logic                  core_rst,
	input wire logic                  low_power,
	input wire frc_pkg::frc_clk_cfg_t clk_cfg,
	input wire frc_pkg::frc_params_t  params,
	input wire logic [5:0]            id_to_data_gap,
	// Disk side
	input wire logic                  write_req,
	input wire logic [7:0]            bytes_to_preamble,
	input wire logic                  write_gate_output,
	input wire logic                  rate_indicator_pin,
	input wire logic [7:0]            drive_ctrl
);
	logic [5:0] lead;
	logic [7:0] settle_ff;
	logic [7:0] nxt_settle;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Pre-erase lead only applies in perpendicular mode
	assign lead = !params.perp_mode ? 6'h00 : clk_cfg.rate == 2'h3 ? 6'h26 :
		clk_cfg.rate == 2'h0 ? 6'h13 : clk_cfg.rate == 2'h1 ? 6'h0C : 6'h0A;
	// A reset held by the output register is not a settle phase
	always_comb begin
		nxt_settle = 8'h00;
		if (core_rst && !drive_ctrl[frc_pkg::DOR_RST] && settle_ff != 8'hFF)
			nxt_settle = settle_ff + 8'h01;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			settle_ff <= 8'h00;
		else
			settle_ff <= nxt_settle;
	end
	msr_settle_a: assert property (bus.rd && bus.addr == frc_pkg::OFF_MSR_DSR && core_rst
		|=> rdata == 8'h00) else $error("status not zero while settling");
	settle_len_a: assert property (settle_ff <= 8'h15)
		else $error("settle phase too long");
	rate_pin_a: assert property (rate_indicator_pin == clk_cfg.rate[0])
		else $error("rate pin differs from rate");
	ccr_rate_a: assert property (bus.wr && bus.addr == frc_pkg::OFF_CCR
		|=> clk_cfg.rate == $past(bus.wdata[1:0])) else $error("rate not taken");
	clk_scale_a: assert property (clk_cfg.speed == (clk_cfg.rate == 2'h3 ? 5'h14 :
		clk_cfg.rate == 2'h2 ? 5'h05 : clk_cfg.rate == 2'h1 ? 5'h06 : 5'h0A))
		else $error("clock scale wrong for rate");
	filter_sel_a: assert property (clk_cfg.filter == 4'h1 << clk_cfg.rate)
		else $error("filter wrong for rate");
	gap_len_a: assert property (id_to_data_gap == (params.perp_mode ? 6'h29 : 6'h16))
		else $error("gap length wrong");
	lp_gate_a: assert property (low_power |-> !core_clk_en)
		else $error("core clock runs in power down");
	lp_entry_a: assert property (bus.wr && bus.addr == frc_pkg::OFF_MSR_DSR &&
		bus.wdata[6] && !bus.wdata[7] && !core_rst && !low_power |=> ##1 low_power)
		else $error("low power not entered");
	soft_rst_a: assert property (bus.wr && bus.addr == frc_pkg::OFF_MSR_DSR &&
		bus.wdata[7] |=> core_rst && !low_power) else $error("soft reset not taken");
	write_gate_output_lead_a: assert property (write_gate_output |->
		$past(write_req && core_clk_en && bytes_to_preamble <= {2'h0, lead}))
		else $error("write gate out of place");
	wake_block_a: assert property (low_power |-> !data_rd && !data_wr)
		else $error("core access in power down");
	cover property ($rose(low_power));
	cover property ($rose(write_gate_output));
	cover property ($fell(core_rst));
endmodule

bind frc_ctrl frc_ctrl_properties u_props (
	.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .data_rd(data_rd),
	.data_wr(data_wr), .core_clk_en(core_clk_en), .core_rst(core_rst),
	.low_power(low_power), .clk_cfg(clk_cfg), .params(params),
	.id_to_data_gap(id_to_data_gap), .write_req(write_req),
	.bytes_to_preamble(bytes_to_preamble), .write_gate_output(write_gate_output),
	.rate_indicator_pin(rate_indicator_pin), .drive_ctrl(drive_ctrl)
);

// File: sim/frc_ctrl_tb.sv
// Self-checking bench for the rate, power and reset control block
`timescale 1ns/100ps
module frc_ctrl_tb;
	localparam logic [9:0] A_DOR = frc_pkg::OFF_DOR;
	localparam logic [9:0] A_SEL = frc_pkg::OFF_MSR_DSR;
	localparam logic [9:0] A_DAT = frc_pkg::OFF_DATA;
	localparam logic [9:0] A_MOD = frc_pkg::OFF_MODE;
	localparam logic [9:0] A_CNF = frc_pkg::OFF_CONF;
	localparam logic [9:0] A_CCR = frc_pkg::OFF_CCR;
	frc_pkg::frc_bus_req_t bus;
	frc_pkg::frc_clk_cfg_t clk_cfg;
	frc_pkg::frc_params_t  params;
	logic                  mclk, rst_n, core_idle, data_rd, data_wr, core_clk_en, core_rst;
	logic                  low_power, write_req, write_gate_output, rate_indicator_pin;
	logic [7:0]            rdata, core_msr, data_rdata, data_wdata, precomp_start_track;
	logic [7:0]            bytes_to_preamble, drive_ctrl;
	logic [5:0]            id_to_data_gap;
	logic [2:0]            precomp_sel;
	int                    mismatches, num_checks, cycles, n;
	logic [4:0]            speeds [4] = '{5'h0A, 5'h06, 5'h05, 5'h14};
	logic [7:0]            leads [3] = '{8'h25, 8'h12, 8'h00};
	logic [7:0]            lp_rate [3] = '{8'h00, 8'h03, 8'h02};
	int                    lp_min [3] = '{20, 10, 40};

	frc_ctrl #(.AUTO_LP_CYCLES(20), .OSC_CYCLES(8)) u_dut (
		.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .core_idle(core_idle),
		.core_msr(core_msr), .data_rdata(data_rdata), .data_rd(data_rd),
		.data_wr(data_wr), .data_wdata(data_wdata), .core_clk_en(core_clk_en),
		.core_rst(core_rst), .low_power(low_power), .clk_cfg(clk_cfg), .params(params),
		.precomp_sel(precomp_sel), .precomp_start_track(precomp_start_track),
		.id_to_data_gap(id_to_data_gap), .write_req(write_req),
		.bytes_to_preamble(bytes_to_preamble), .write_gate_output(write_gate_output),
		.rate_indicator_pin(rate_indicator_pin), .drive_ctrl(drive_ctrl));
	frc_core_model u_core (
		.mclk(mclk), .rst_n(rst_n), .core_clk_en(core_clk_en), .data_wr(data_wr),
		.data_wdata(data_wdata), .core_idle(core_idle), .core_msr(core_msr),
		.data_rdata(data_rdata), .write_req(write_req),
		.bytes_to_preamble(bytes_to_preamble));

	initial mclk = 1'b0;
	always #25 mclk = ~mclk;
	// Whole run needs about 650 cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge mclk);
		bus.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string name);
		@(posedge mclk);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1;
		check(name, exp, rdata);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	initial begin
		rst_n = 1'b0;
		bus = '0;
		mismatches = 0;
		num_checks = 0;
		cycles = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(A_SEL, 8'h00, "status settling");
		rd(A_DOR, 8'h00, "dor in settle");
		idle(25);
		rd(A_SEL, 8'h80, "status ready");
		check("fifo default", 8'h00, {params.fifo_en, params.fifo_threshold_param});
		check("poll default", 8'h01, {params.implied_seek, params.poll_en});
		check("track default", 8'h00, precomp_start_track);
		check("precomp default", 8'h00, precomp_sel);
		$display("defaults done");
		for (int i = 0; i < 4; i++) begin
			wr(A_CCR, 8'(i));
			check("ccr rate", 8'(i), clk_cfg.rate);
			check("speed", speeds[i], clk_cfg.speed);
			check("filter", 8'h01 << i, clk_cfg.filter);
			check("rate pin", 8'(i & 1), rate_indicator_pin);
			wr(A_SEL, 8'(3 - i));
			check("dsr rate", 8'(3 - i), clk_cfg.rate);
			check("dsr speed", speeds[3 - i], clk_cfg.speed);
		end
		wr(A_SEL, 8'h14);
		check("precomp", 8'h05, precomp_sel);
		wr(frc_pkg::OFF_PRECOMP_START_TRACK, 8'h07);
		check("start track", 8'h07, precomp_start_track);
		$display("rates done");
		for (int i = 0; i < 3; i++) begin
			wr(A_MOD, i < 2 ? 8'h20 : 8'h00);
			wr(A_CCR, i == 1 ? 8'h00 : 8'h03);
			check("gap", i < 2 ? 8'h29 : 8'h16, id_to_data_gap);
			wr(A_DAT, 8'h80);
			n = 0;
			while (!write_gate_output && n < 100) begin
				idle(1);
				n++;
			end
			check("preamble lead", leads[i], bytes_to_preamble);
			idle(50);
		end
		$display("write gate done");
		wr(A_DOR, 8'h30);
		wr(A_SEL, 8'h40);
		// Entry follows the registered low power bit by one cycle
		idle(1);
		check("lp entry", 8'h02, {low_power, core_clk_en});
		check("drive ctrl", 8'h30, drive_ctrl);
		rd(A_DOR, 8'h30, "dor in power down");
		rd(A_SEL, 8'h00, "wake status");
		idle(12);
		rd(A_SEL, 8'h80, "status after wake");
		wr(A_DOR, 8'h00);
		wr(A_MOD, 8'h01);
		idle(1);
		check("mode lp", 8'h01, low_power);
		rd(A_DAT, 8'h00, "data wake");
		idle(12);
		rd(A_MOD, 8'h00, "mode lp cleared");
		$display("low power done");
		wr(A_CNF, 8'h03);
		wr(A_MOD, 8'h9C);
		wr(A_SEL, 8'h80);
		check("dsr reset", 8'h01, core_rst);
		rd(A_MOD, 8'h9C, "mode in reset");
		idle(25);
		check("reset self clear", 8'h00, core_rst);
		rd(A_CNF, 8'h03, "conf kept");
		check("track kept", 8'h07, precomp_start_track);
		check("lock kept", 8'h07, {params.burst_disable, params.fifo_read_disable,
		      params.fifo_write_disable});
		wr(A_MOD, 8'h1C);
		wr(A_DOR, 8'h04);
		idle(40);
		check("dor reset held", 8'h01, core_rst);
		wr(A_DOR, 8'h00);
		idle(25);
		rd(A_MOD, 8'h00, "mode cleared");
		wr(A_SEL, 8'h40);
		wr(A_SEL, 8'h80);
		check("reset wakes", 8'h01, {low_power, core_rst});
		idle(25);
		$display("resets done");
		wr(A_MOD, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr(A_CCR, lp_rate[i]);
			wr(A_DAT, 8'h01);
			n = 0;
			while (!low_power && n < 100) begin
				idle(1);
				n++;
			end
			check("auto lp delay", 8'h01, 8'(n >= lp_min[i] && n <= lp_min[i] + 8));
			rd(A_SEL, 8'h00, "auto wake");
			idle(12);
		end
		$display("auto low power done");
		complete_run();
	end
endmodule
